// ==== design/rcr_pkg.sv ====
// rcr_pkg: constants for the regulator configuration register slice
// assumes a serial bus engine outside presents byte-wide register accesses
package rcr_pkg;
	// register addresses
	localparam logic [7:0] ADDR_CH4_VOLTAGE_SELECT  = 8'h04;
	localparam logic [7:0] ADDR_SCALING_CONFIG      = 8'h05;
	localparam logic [7:0] ADDR_MODE_DISCHARGE_CFG  = 8'h06;
	// field positions and channel count
	localparam int CH4_CODE_MSB        = 4;
	localparam int CH4_SCALE_EN_BIT    = 6;
	localparam int CH4_INTERVAL_LSB    = 4;
	localparam int CH1_SCALE_EN_BIT    = 2;
	localparam int CH1_INTERVAL_LSB    = 0;
	localparam int POWER_SAVE_LSB      = 0;
	localparam int DISCHARGE_LSB       = 4;
	localparam int NUM_CHANNELS        = 4;
	// reset values and the adjustable reference code
	localparam logic [7:0] SCALING_CONFIG_RESET = 8'h00;
	localparam logic [3:0] POWER_SAVE_RESET     = 4'h0;
	localparam logic [4:0] CODE_ADJUSTABLE      = 5'h00;
	// interval selects
	localparam logic [1:0] INTERVAL_62US5 = 2'h0;
	localparam logic [1:0] INTERVAL_31US2 = 2'h1;
	localparam logic [1:0] INTERVAL_15US6 = 2'h2;
	localparam logic [1:0] INTERVAL_7US8  = 2'h3;
	// interval times in ns and cycle counts at 50 MHz (longest time, rounded down)
	localparam int CLK_PERIOD_NS  = 20;
	localparam int T_62US5_NS     = 62500;
	localparam int T_31US2_NS     = 31200;
	localparam int T_15US6_NS     = 15600;
	localparam int T_7US8_NS      = 7800;
	localparam logic [11:0] CYC_62US5 = 12'(T_62US5_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CYC_31US2 = 12'(T_31US2_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CYC_15US6 = 12'(T_15US6_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CYC_7US8  = 12'(T_7US8_NS / CLK_PERIOD_NS);
	// target in millivolts for code steps of 100 mV above 2.4 V
	localparam logic [12:0] MV_ADJUSTABLE = 13'h0320;
	localparam logic [12:0] MV_CODE_BASE  = 13'h0960;
	localparam logic [12:0] MV_CODE_STEP  = 13'h0064;
endpackage : rcr_pkg

// ==== design/rcr_interval_timer.sv ====
// rcr_interval_timer: one tick per selected scaling interval
// assumes run_i is held while stepping is wanted
`timescale 1ns/10ps
module rcr_interval_timer
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// control
	input  wire logic       run_i,
	input  wire logic [1:0] interval_i,
	// tick
	output logic            tick_o
);
	typedef struct packed
	{
		logic [11:0] count;
		logic        tick;
	} rcr_tmr_state_t;

	rcr_tmr_state_t state_q;
	rcr_tmr_state_t state_d;
	logic [11:0]    period;

	function automatic logic [11:0] interval_cycles(input logic [1:0] sel);
		unique case (sel)
			rcr_pkg::INTERVAL_62US5: interval_cycles = rcr_pkg::CYC_62US5;
			rcr_pkg::INTERVAL_31US2: interval_cycles = rcr_pkg::CYC_31US2;
			rcr_pkg::INTERVAL_15US6: interval_cycles = rcr_pkg::CYC_15US6;
			rcr_pkg::INTERVAL_7US8:  interval_cycles = rcr_pkg::CYC_7US8;
		endcase
	endfunction : interval_cycles

	always_comb
	begin
		period = interval_cycles(interval_i);
		state_d = state_q;
		state_d.tick = 1'b0;
		if (!run_i)
			state_d.count = 12'h000;
		else if (state_q.count >= period - 12'h001)
		begin
			state_d.count = 12'h000;
			state_d.tick = 1'b1;
		end
		else
			state_d.count = state_q.count + 12'h001;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign tick_o = state_q.tick;
endmodule : rcr_interval_timer

// ==== design/rcr_code_to_mv.sv ====
// rcr_code_to_mv: channel 4 code to target millivolts and reference mode
// combinational; the caller registers the results
`timescale 1ns/10ps
module rcr_code_to_mv
(
	// code in
	input  wire logic [4:0]  code_i,
	// decoded target
	output logic [12:0]      target_mv_o,
	output logic             adjustable_o
);
	always_comb
	begin
		adjustable_o = (code_i == rcr_pkg::CODE_ADJUSTABLE);
		if (adjustable_o)
			target_mv_o = rcr_pkg::MV_ADJUSTABLE;
		else
			target_mv_o = 13'(rcr_pkg::MV_CODE_BASE
				+ 13'(rcr_pkg::MV_CODE_STEP * 13'(code_i)));
	end
endmodule : rcr_code_to_mv

// ==== design/rcr_regs.sv ====
// rcr_regs: configuration registers for channel 4 voltage, scaling, mode and discharge
// assumes the serial bus engine gives one-cycle write strobes and samples read data
// the cycle after a read address is presented; fuse values are stable after reset
//
// Notes on behaviour
// - five-bit channel 4 code, fuse reset value
// - code drives channel 4 target, 100 mV steps
// - code zero selects adjustable 0.8 V reference
// - channel 4 scaling enable bit 6, reset off
// - channel 1 scaling enable bit 2, reset off
// - channel 4 interval bits 5:4, four rates
// - channel 1 interval bits 1:0, same mapping
// - power-save bits apply when mode pin high/clock
// - mode pin low forces auto power-save, bits kept
// - power-save bits 3:0, reset forced pulse width
// - discharge enables bits 7:4, one per channel
// - discharge enables reset from one fuse
// - registers at 0x04, 0x05, 0x06, reserved writable
`timescale 1ns/10ps
module rcr_regs
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	// register access from the serial bus engine
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_rd_i,
	output logic [7:0]      reg_rdata_o,
	// factory fuses
	input  wire logic [4:0] fuse_ch4_code_i,
	input  wire logic       fuse_discharge_i,
	// mode pin: high level, or configured as clock in/out
	input  wire logic       mode_pin_i,
	input  wire logic       mode_pin_is_clock_i,
	// channel controls
	output logic [4:0]      ch4_applied_code_o,
	output logic [12:0]     ch4_target_mv_o,
	output logic            ch4_adjustable_o,
	output logic [3:0]      power_save_operation_o,
	output logic [3:0]      discharge_enable_o,
	output logic            ch1_scaling_enable_o,
	output logic [1:0]      ch1_scaling_interval_o
);
	typedef enum logic [1:0] {ST_RESET, ST_LOAD, ST_RUN} rcr_phase_t;

	typedef struct packed
	{
		rcr_phase_t  phase;
		logic [7:0]  ch4_voltage_select;
		logic [7:0]  voltage_scaling_config;
		logic [7:0]  mode_discharge_config;
		logic [4:0]  applied_code;
		logic [12:0] target_mv;
		logic        adjustable;
		logic [3:0]  power_save;
		logic [7:0]  rdata;
	} rcr_state_t;

	rcr_state_t  state_q;
	rcr_state_t  state_d;
	logic        ch4_scaling_enable;
	logic [1:0]  ch4_scaling_interval;
	logic [4:0]  ch4_voltage_code;
	logic        step_tick;
	logic [12:0] dec_mv;
	logic        dec_adj;

	assign ch4_voltage_code     = state_q.ch4_voltage_select[rcr_pkg::CH4_CODE_MSB:0];
	assign ch4_scaling_enable   = state_q.voltage_scaling_config[rcr_pkg::CH4_SCALE_EN_BIT];
	assign ch4_scaling_interval =
		state_q.voltage_scaling_config[rcr_pkg::CH4_INTERVAL_LSB +: 2];

	// stepping only runs while enabled and not yet at target
	rcr_interval_timer u_step_timer
	(
		.clk_sys_i  (clk_sys_i),
		.rst_n_i    (rst_n_i),
		.run_i      (ch4_scaling_enable && (state_q.applied_code != ch4_voltage_code)),
		.interval_i (ch4_scaling_interval),
		.tick_o     (step_tick)
	);

	rcr_code_to_mv u_decode
	(
		.code_i       (state_q.applied_code),
		.target_mv_o  (dec_mv),
		.adjustable_o (dec_adj)
	);

	function automatic logic [7:0] read_mux(input logic [7:0] addr, input rcr_state_t s);
		unique case (addr)
			rcr_pkg::ADDR_CH4_VOLTAGE_SELECT: read_mux = s.ch4_voltage_select;
			rcr_pkg::ADDR_SCALING_CONFIG:     read_mux = s.voltage_scaling_config;
			rcr_pkg::ADDR_MODE_DISCHARGE_CFG: read_mux = s.mode_discharge_config;
			default:                          read_mux = 8'h00;
		endcase
	endfunction : read_mux

	always_comb
	begin
		state_d = state_q;
		unique case (state_q.phase)
			ST_RESET:
				state_d.phase = ST_LOAD;
			ST_LOAD:
			begin
				// fuses caught after reset release, not under the async reset
				state_d.ch4_voltage_select = {3'h0, fuse_ch4_code_i};
				state_d.mode_discharge_config =
					{{rcr_pkg::NUM_CHANNELS{fuse_discharge_i}}, rcr_pkg::POWER_SAVE_RESET};
				state_d.applied_code = fuse_ch4_code_i;
				state_d.phase = ST_RUN;
			end
			ST_RUN:
			begin
				if (reg_wr_i)
				begin
					// full byte stored, reserved bits included
					unique case (reg_addr_i)
						rcr_pkg::ADDR_CH4_VOLTAGE_SELECT:
							state_d.ch4_voltage_select = reg_wdata_i;
						rcr_pkg::ADDR_SCALING_CONFIG:
							state_d.voltage_scaling_config = reg_wdata_i;
						rcr_pkg::ADDR_MODE_DISCHARGE_CFG:
							state_d.mode_discharge_config = reg_wdata_i;
						default:
							state_d.phase = ST_RUN;
					endcase
				end
				// without scaling the applied code follows the register at once
				if (!ch4_scaling_enable)
					state_d.applied_code = ch4_voltage_code;
				else if (step_tick)
				begin
					if (state_q.applied_code < ch4_voltage_code)
						state_d.applied_code = state_q.applied_code + 5'h01;
					else if (state_q.applied_code > ch4_voltage_code)
						state_d.applied_code = state_q.applied_code - 5'h01;
				end
			end
			// unused phase code restarts the fuse load
			default:
				state_d.phase = ST_RESET;
		endcase
		state_d.target_mv = dec_mv;
		state_d.adjustable = dec_adj;
		// pin low forces auto mode; stored bits are left untouched
		if (mode_pin_i || mode_pin_is_clock_i)
			state_d.power_save =
				state_q.mode_discharge_config[rcr_pkg::POWER_SAVE_LSB +: 4];
		else
			state_d.power_save = 4'hf;
		if (reg_rd_i)
			state_d.rdata = read_mux(reg_addr_i, state_q);
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= '0;
			state_q.phase <= ST_RESET;
			state_q.voltage_scaling_config <= rcr_pkg::SCALING_CONFIG_RESET;
			state_q.target_mv <= rcr_pkg::MV_ADJUSTABLE;
			state_q.adjustable <= 1'b1;
			state_q.power_save <= 4'hf;
		end
		else
			state_q <= state_d;
	end

	assign reg_rdata_o            = state_q.rdata;
	assign ch4_applied_code_o     = state_q.applied_code;
	assign ch4_target_mv_o        = state_q.target_mv;
	assign ch4_adjustable_o       = state_q.adjustable;
	assign power_save_operation_o = state_q.power_save;
	assign discharge_enable_o     =
		state_q.mode_discharge_config[rcr_pkg::DISCHARGE_LSB +: 4];
	assign ch1_scaling_enable_o   = state_q.voltage_scaling_config[rcr_pkg::CH1_SCALE_EN_BIT];
	assign ch1_scaling_interval_o =
		state_q.voltage_scaling_config[rcr_pkg::CH1_INTERVAL_LSB +: 2];
endmodule : rcr_regs

// ==== dv/rcr_regs_chk.sv ====
// rcr_regs_chk: port assertions for the register slice
// sees only rcr_regs ports, bound below
`timescale 1ns/10ps
module rcr_regs_chk
(
	// clock, reset, bus
	input wire logic        clk_sys_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic        reg_wr_i,
	input wire logic [7:0]  reg_wdata_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_rdata_o,
	// pins and controls
	input wire logic        mode_pin_i,
	input wire logic        mode_pin_is_clock_i,
	input wire logic [4:0]  ch4_applied_code_o,
	input wire logic [12:0] ch4_target_mv_o,
	input wire logic        ch4_adjustable_o,
	input wire logic [3:0]  power_save_operation_o,
	input wire logic [3:0]  discharge_enable_o,
	input wire logic        ch1_scaling_enable_o,
	input wire logic [1:0]  ch1_scaling_interval_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_unmap;
		reg_rd_i && !(reg_addr_i inside {[8'h04:8'h06]}) |=> reg_rdata_o == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("rdata moved");
	property p_target;
		ch4_target_mv_o == (($past(ch4_applied_code_o) == 5'h00) ? 13'h0320 :
			13'h0960 + 13'h0064 * {8'h00, $past(ch4_applied_code_o)});
	endproperty
	a_target: assert property (p_target) else $error("target");
	property p_adj; ch4_adjustable_o == ($past(ch4_applied_code_o) == 5'h00); endproperty
	a_adj: assert property (p_adj) else $error("adjustable");
	property p_forced; !mode_pin_i && !mode_pin_is_clock_i |=> power_save_operation_o == 4'hf;
	endproperty
	a_forced: assert property (p_forced) else $error("forced");
	property p_psave;
		reg_wr_i && reg_addr_i == 8'h06 && mode_pin_i ##1 mode_pin_i && !reg_wr_i
			|=> power_save_operation_o == $past(reg_wdata_i[3:0], 2);
	endproperty
	a_psave: assert property (p_psave) else $error("power save");
	property p_ch1;
		reg_wr_i && reg_addr_i == 8'h05
			|=> {ch1_scaling_enable_o, ch1_scaling_interval_o} == $past(reg_wdata_i[2:0]);
	endproperty
	a_ch1: assert property (p_ch1) else $error("ch1 scaling");
	property p_dis; reg_wr_i && reg_addr_i == 8'h06 |=> discharge_enable_o == $past(reg_wdata_i[7:4]);
	endproperty
	a_dis: assert property (p_dis) else $error("discharge");
endmodule : rcr_regs_chk
bind rcr_regs rcr_regs_chk u_rcr_regs_chk (.*);

// ==== dv/rcr_host_model.sv ====
// rcr_host_model: host on the register bus, one access at a time
// signals move just after rising edges; idle address is scrambled
`timescale 1ns/10ps
module rcr_host_model
(
	// clock
	input  wire logic       clk_sys_i,
	// register bus
	output logic [7:0]      addr_o,
	output logic            wr_o,
	output logic [7:0]      wdata_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);
	initial {addr_o, wr_o, wdata_o, rd_o} = 18'h0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		{addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
		@(posedge clk_sys_i);
		{addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		{addr_o, rd_o} <= {a, 1'b1};
		@(posedge clk_sys_i);
		{addr_o, rd_o} <= {~a, 1'b0};
		#1 d = rdata_i;
	endtask : rd
endmodule : rcr_host_model

// ==== dv/rcr_regs_test.sv ====
// rcr_regs_test: register slice against a behavioural register model
// host accesses via rcr_host_model; fuses and mode pins driven here
`timescale 1ns/10ps
module rcr_regs_test;
	logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, mode_pin_i = 1'b1, mode_pin_is_clock_i = 1'b0;
	logic        reg_wr_i, reg_rd_i, fuse_discharge_i, ch4_adjustable_o, ch1_scaling_enable_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, rv, wv;
	logic [4:0]  fuse_ch4_code_i, ch4_applied_code_o;
	logic [12:0] ch4_target_mv_o;
	logic [3:0]  power_save_operation_o, discharge_enable_o;
	logic [1:0]  ch1_scaling_interval_o;
	int          failures = 0, samples_checked = 0, seed = 32'h9203, n, i;
	int          mem [4:6];
	int          codes [7] = '{0, 1, 2, 6, 16, 26, 31};
	always #10 clk_sys_i = ~clk_sys_i;
	rcr_regs u_rcr_regs (.*);
	rcr_host_model u_rcr_host_model (.clk_sys_i(clk_sys_i), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
		.wdata_o(reg_wdata_i), .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));
	task automatic end_sim;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic rdchk(input int a);
		u_rcr_host_model.rd(8'(a), rv);
		chk("rdata", 13'(rv), 13'((a inside {[4:6]}) ? mem[a] : 0));
	endtask : rdchk
	initial
	begin
		@(posedge clk_sys_i);
		fuse_ch4_code_i <= 5'($random(seed));
		fuse_discharge_i <= 1'($random(seed));
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		// reset values: fuse code, fuse discharge, scaling and power-save off
		mem[4] = fuse_ch4_code_i;
		mem[5] = 0;
		mem[6] = {fuse_discharge_i, fuse_discharge_i, fuse_discharge_i, fuse_discharge_i, 4'h0};
		#1 chk("dis", 13'(discharge_enable_o), 13'({4{fuse_discharge_i}}));
		for (i = 3; i < 8; i++) rdchk(i);
		for (n = 0; n < 24; n++)
		begin
			i = 3 + ($unsigned($random(seed)) % 5);
			wv = 8'($random(seed));
			u_rcr_host_model.wr(8'(i), wv);
			if (i inside {[4:6]}) mem[i] = wv;
			rdchk(i);
			chk("ch1", 13'({ch1_scaling_enable_o, ch1_scaling_interval_o}), 13'(mem[5] & 7));
			chk("dis", 13'(discharge_enable_o), 13'(mem[6] >> 4));
		end
		u_rcr_host_model.wr(8'h05, 8'h00);
		foreach (codes[k])
		begin
			u_rcr_host_model.wr(8'(codes[k]), 8'h00);
			u_rcr_host_model.wr(8'h04, 8'(codes[k]));
			repeat (3) @(posedge clk_sys_i);
			#1 chk("mv", ch4_target_mv_o, 13'(codes[k] ? 2400 + 100 * codes[k] : 800));
			chk("adj", 13'(ch4_adjustable_o), 13'(codes[k] == 0));
		end
		u_rcr_host_model.wr(8'h06, 8'h05);
		mem[6] = 5;
		for (n = 0; n < 4; n++)
		begin
			@(posedge clk_sys_i);
			{mode_pin_is_clock_i, mode_pin_i} <= 2'(n);
			repeat (2) @(posedge clk_sys_i);
			#1 chk("ps", 13'(power_save_operation_o), n ? 13'h0005 : 13'h000f);
		end
		rdchk(6);
		// scaling on at the fastest rate, target two counts away
		u_rcr_host_model.wr(8'h04, 8'h02);
		u_rcr_host_model.wr(8'h05, 8'h70);
		u_rcr_host_model.wr(8'h04, 8'h04);
		for (i = 0; i < 2; i++)
		begin
			n = 0;
			while (ch4_applied_code_o === 5'(2 + i) && n < 500)
			begin
				@(posedge clk_sys_i);
				// look at the settled value, not the launching edge
				#1;
				n++;
			end
			#1 chk("step", 13'(ch4_applied_code_o), 13'(3 + i));
			chk("gap", 13'(i == 0 || (n > 388 && n < 392)), 13'h0001);
			if (n == 500) end_sim();
		end
		end_sim();
	end
endmodule : rcr_regs_test
